// [rtl/fta_consts.svh]
/*
  Constants of the float-to-text formatter: register offsets, limits,
  float field values and character codes.
  Assumes inclusion by the divider and formatter modules only.
*/
`ifndef FTA_CONSTS_SVH
`define FTA_CONSTS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define FTA_ADDR_W      8
`define FTA_OFS_SRC_LO  8'h00
`define FTA_OFS_SRC_HI  8'h04
`define FTA_OFS_FMT     8'h08
`define FTA_OFS_TOTAL   8'h0C
`define FTA_OFS_FRAC    8'h10
`define FTA_OFS_CMD     8'h14
`define FTA_OFS_STAT    8'h18
`define FTA_OFS_DEST    8'h40
`define FTA_DEST_WORDS  13
`define FTA_RESP_OKAY   2'h0
`define FTA_RESP_DECERR 2'h3

// ----------------------------------------------------------------
// format limits
// ----------------------------------------------------------------
`define FTA_FMT_SCI     16'h0001
`define FTA_TOTAL_MAX   16'h0018
`define FTA_FRAC_MAX    16'h0007
`define FTA_DEC_MIN     16'h0002
`define FTA_SCI_MIN     16'h0006
`define FTA_DEC_EXTRA   16'h0003
`define FTA_SCI_EXTRA   16'h0007

// ----------------------------------------------------------------
// float fields and scaling
// ----------------------------------------------------------------
`define FTA_EXP_ALL1    8'hFF
`define FTA_EXP_BIAS    10'sh07F
`define FTA_DENORM_EXP  10'sh382
`define FTA_MANT_TOP    10'sh01F
`define FTA_SCI_TOP_EXP 10'sh003
`define FTA_NRM3        10'sh003
`define FTA_NRM4        10'sh004
`define FTA_TEN_MANT    32'hA0000000
`define FTA_TENTH       32'hCCCCCCCD
`define FTA_TEN         8'h0A

// ----------------------------------------------------------------
// characters
// ----------------------------------------------------------------
`define FTA_CH_ZERO     8'h30
`define FTA_CH_DOT      8'h2E
`define FTA_CH_E        8'h45
`define FTA_CH_MINUS    8'h2D
`define FTA_CH_PLUS     8'h2B
`define FTA_CH_SPACE    8'h20

`endif

// [rtl/fta_pkg.sv]
/*
  Types of the float-to-text formatter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fta_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_NORM, ST_ROUND, ST_EMIT, ST_COMMIT
  } fta_state_t;
  typedef enum logic [2:0] {
    SG_EU, SG_ET, SG_ES, SG_E, SG_FRAC, SG_DOT, SG_INT, SG_PAD
  } fta_stage_t;
endpackage

// [rtl/fta_div10.sv]
/*
  Divide-by-ten of a wide unsigned value, quotient and remainder.
  Assumes a combinational use inside the formatter's digit loop.
*/
`timescale 1ns/1ps
`include "fta_consts.svh"
module fta_div10 #(
  parameter int W = 160
) (
  input  wire logic [W-1:0] num_i,
  output logic      [W-1:0] quot_o,
  output logic      [3:0]   rem_o
);
  localparam logic [W-1:0] TEN = W'(`FTA_TEN);
  logic [W-1:0] rem_w;

  assign quot_o = num_i / TEN;
  assign rem_w  = num_i % TEN;
  assign rem_o  = rem_w[3:0];
endmodule // fta_div10

// [rtl/fta_formatter.sv]
/*
  Float-to-text execution unit with an AXI4-Lite register slave.
  Assumes one 20 MHz clock, and a sequencer that loads source and
  control words, writes the start bit and reads back the text words.
*/
// The AXI4-Lite register port and the register addresses were left to the implementer.
// Functional notes
// - source float is upper word then lower word
// - three control words: notation, total, fraction
// - notation 0 decimal, 1 scientific, else fault
// - NaN source raises fault
// - infinite source raises fault
// - total counts sign, digits, point, spaces
// - fraction digits never above seven
// - two characters per word, upper byte first
// - zero byte if odd, zero word if even
// - decimal, no fraction: total 2 to 24
// - decimal fraction: total fraction+3 to 24
// - scientific, no fraction: total 6 to 24
// - scientific fraction: total fraction+7 to 24
// - bad total raises fault
// - bad fraction count raises fault
// - integer digits limited by remaining width
// - scientific has one integer digit, exponent
// - zero flag only for zero result
`timescale 1ns/1ps
`include "fta_consts.svh"
module fta_formatter #(
  parameter int AW = `FTA_ADDR_W,
  parameter int NW = `FTA_DEST_WORDS
) (
  input  wire logic          CORE_CLK_I,
  input  wire logic          RST_N_I,
  input  wire logic [AW-1:0] S_AXI_AWADDR_I,
  input  wire logic          S_AXI_AWVALID_I,
  output logic               S_AXI_AWREADY_O,
  input  wire logic [31:0]   S_AXI_WDATA_I,
  input  wire logic [3:0]    S_AXI_WSTRB_I,
  input  wire logic          S_AXI_WVALID_I,
  output logic               S_AXI_WREADY_O,
  output logic [1:0]         S_AXI_BRESP_O,
  output logic               S_AXI_BVALID_O,
  input  wire logic          S_AXI_BREADY_I,
  input  wire logic [AW-1:0] S_AXI_ARADDR_I,
  input  wire logic          S_AXI_ARVALID_I,
  output logic               S_AXI_ARREADY_O,
  output logic [31:0]        S_AXI_RDATA_O,
  output logic [1:0]         S_AXI_RRESP_O,
  output logic               S_AXI_RVALID_O,
  input  wire logic          S_AXI_RREADY_I,
  output logic               FAULT_INDICATOR_O,
  output logic               ZERO_RESULT_INDICATOR_O,
  output logic               BUSY_O
);
  import fta_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic              aw_hold;
  logic              w_hold;
  logic [AW-1:0]     aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [15:0]       src_lo;
  logic [15:0]       src_hi;
  logic [15:0]       fmt_r;
  logic [15:0]       total_r;
  logic [15:0]       frac_r;
  fta_state_t        st;
  fta_stage_t        sg;
  logic [31:0]       src;
  logic [15:0]       cf_fmt;
  logic [15:0]       cf_total;
  logic [15:0]       cf_frac;
  logic              neg;
  logic [31:0]       mant;
  logic signed [9:0] bexp;
  logic signed [7:0] dexp;
  logic [159:0]      n;
  logic [4:0]        pos;
  logic [2:0]        cnt;
  logic              fault;
  logic              zero;
  logic              done;
  logic [7:0]        text [0:2*NW-1];
  logic [15:0]       dest [0:NW-1];

  function automatic logic [27:0] p10(input logic [3:0] k);
    case (k)
      4'h0:    p10 = 28'h0000001;
      4'h1:    p10 = 28'h000000A;
      4'h2:    p10 = 28'h0000064;
      4'h3:    p10 = 28'h00003E8;
      4'h4:    p10 = 28'h0002710;
      4'h5:    p10 = 28'h00186A0;
      4'h6:    p10 = 28'h00F4240;
      4'h7:    p10 = 28'h0989680;
      default: p10 = 28'h5F5E100;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  wire wr_go = aw_hold && w_hold && !S_AXI_BVALID_O;
  wire aw_hs = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  wire w_hs  = S_AXI_WVALID_I && S_AXI_WREADY_O;
  wire wa_lo = aw_addr == AW'(`FTA_OFS_SRC_LO);
  wire wa_hi = aw_addr == AW'(`FTA_OFS_SRC_HI);
  wire wa_fm = aw_addr == AW'(`FTA_OFS_FMT);
  wire wa_tt = aw_addr == AW'(`FTA_OFS_TOTAL);
  wire wa_fr = aw_addr == AW'(`FTA_OFS_FRAC);
  wire wa_cm = aw_addr == AW'(`FTA_OFS_CMD);
  wire wa_ok = wa_lo | wa_hi | wa_fm | wa_tt | wa_fr | wa_cm;
  wire go    = wr_go && wa_cm && w_strb[0] && w_data[0];
  wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  assign S_AXI_AWREADY_O = !aw_hold && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = !w_hold && !S_AXI_BVALID_O;

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold        <= 1'b0;
      w_hold         <= 1'b0;
      aw_addr        <= '0;
      w_data         <= '0;
      w_strb         <= '0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= `FTA_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end
      if (w_hs) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      if (wr_go) begin
        aw_hold        <= 1'b0;
        w_hold         <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wa_ok ? `FTA_RESP_OKAY : `FTA_RESP_DECERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // the unit latches its own copy at start, so these may change later
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      src_lo  <= '0;
      src_hi  <= '0;
      fmt_r   <= '0;
      total_r <= '0;
      frac_r  <= '0;
    end else if (wr_go) begin
      if (wa_lo) src_lo  <= (src_lo & ~wmask) | (w_data[15:0] & wmask);
      if (wa_hi) src_hi  <= (src_hi & ~wmask) | (w_data[15:0] & wmask);
      if (wa_fm) fmt_r   <= (fmt_r & ~wmask) | (w_data[15:0] & wmask);
      if (wa_tt) total_r <= (total_r & ~wmask) | (w_data[15:0] & wmask);
      if (wa_fr) frac_r  <= (frac_r & ~wmask) | (w_data[15:0] & wmask);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire [AW-1:0] ra   = S_AXI_ARADDR_I;
  wire [AW-1:0] dofs = ra - AW'(`FTA_OFS_DEST);
  wire [3:0]    didx = dofs[5:2];
  wire rd_dst = ra[1:0] == 2'h0 && ra >= AW'(`FTA_OFS_DEST)
                && dofs[AW-1:2] < (AW-2)'(NW);
  wire [31:0] stat = {28'h0000000, zero, fault, done, BUSY_O};
  wire [31:0] rd_val =
      ra == AW'(`FTA_OFS_SRC_LO) ? {16'h0000, src_lo}  :
      ra == AW'(`FTA_OFS_SRC_HI) ? {16'h0000, src_hi}  :
      ra == AW'(`FTA_OFS_FMT)    ? {16'h0000, fmt_r}   :
      ra == AW'(`FTA_OFS_TOTAL)  ? {16'h0000, total_r} :
      ra == AW'(`FTA_OFS_FRAC)   ? {16'h0000, frac_r}  :
      ra == AW'(`FTA_OFS_STAT)   ? stat                :
      rd_dst                     ? {16'h0000, dest[didx]} : 32'h00000000;
  wire rd_ok = rd_dst || ra == AW'(`FTA_OFS_SRC_LO)
               || ra == AW'(`FTA_OFS_SRC_HI) || ra == AW'(`FTA_OFS_FMT)
               || ra == AW'(`FTA_OFS_TOTAL) || ra == AW'(`FTA_OFS_FRAC)
               || ra == AW'(`FTA_OFS_STAT) || ra == AW'(`FTA_OFS_CMD);

  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= '0;
      S_AXI_RRESP_O  <= `FTA_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= rd_val;
      S_AXI_RRESP_O  <= rd_ok ? `FTA_RESP_OKAY : `FTA_RESP_DECERR;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // operand checks
  // ----------------------------------------------------------------
  wire [7:0]  fexp     = src[30:23];
  wire [22:0] ffrac    = src[22:0];
  wire        is_nan   = fexp == `FTA_EXP_ALL1 && ffrac != '0;
  wire        is_inf   = fexp == `FTA_EXP_ALL1 && ffrac == '0;
  wire        is_zero  = fexp == '0 && ffrac == '0;
  wire        sci      = cf_fmt == `FTA_FMT_SCI;
  wire        fmt_bad  = cf_fmt > `FTA_FMT_SCI;
  wire        frac_bad = cf_frac > `FTA_FRAC_MAX;
  wire [2:0]  f3       = cf_frac[2:0];
  // least total: sign and digit, plus point, fraction and exponent
  wire [15:0] min_tot  = cf_frac == '0
      ? (sci ? `FTA_SCI_MIN : `FTA_DEC_MIN)
      : cf_frac + (sci ? `FTA_SCI_EXTRA : `FTA_DEC_EXTRA);
  wire tot_bad = cf_total < min_tot || cf_total > `FTA_TOTAL_MAX;
  wire err_any = fmt_bad | frac_bad | tot_bad | is_nan | is_inf;

  // ----------------------------------------------------------------
  // scaling datapath
  // ----------------------------------------------------------------
  // value = mant * 2^(bexp-31); mant is normalised in the decade loop
  wire [63:0] p_tenth = {32'h00000000, mant} * {32'h00000000, `FTA_TENTH};
  wire [35:0] p_ten   = {4'h0, mant} * 36'(`FTA_TEN);
  wire ge10 = !bexp[9] && (bexp > `FTA_SCI_TOP_EXP
              || (bexp == `FTA_SCI_TOP_EXP && mant >= `FTA_TEN_MANT));
  wire lt1  = bexp[9];
  wire [31:0] next_mant =
      !mant[31] ? {mant[30:0], 1'b0} :
      ge10      ? (p_tenth[63] ? p_tenth[63:32] : p_tenth[62:31]) :
                  (p_ten[35] ? p_ten[35:4] : p_ten[34:3]);
  wire signed [9:0] next_bexp =
      !mant[31] ? bexp - 10'sh001 :
      ge10      ? bexp - (p_tenth[63] ? `FTA_NRM3 : `FTA_NRM4) :
                  bexp + (p_ten[35] ? `FTA_NRM4 : `FTA_NRM3);
  // the 0.1 step truncates, so deep decades may lose the last ulp
  wire [59:0]  prod   = mant * p10({1'b0, f3});
  wire [159:0] ext    = {100'h0, prod};
  wire signed [9:0] sh = bexp - `FTA_MANT_TOP;
  wire [9:0]   rsh    = -sh;
  wire [159:0] half   = 160'h1 << (rsh - 10'h001);
  wire [159:0] n_round = sh[9] ? (ext + half) >> rsh : ext << sh[6:0];
  wire [3:0]   f_up   = {1'b0, f3} + 4'h1;
  wire roll = sci && n_round == 160'(p10(f_up));

  // ----------------------------------------------------------------
  // character emission
  // ----------------------------------------------------------------
  logic [159:0] n_q;
  logic [3:0]   n_r;
  fta_div10 #(.W(160)) u_div (
    .num_i  (n),
    .quot_o (n_q),
    .rem_o  (n_r)
  );
  wire [7:0] eabs = dexp[7] ? 8'(-dexp) : 8'(dexp);
  wire [7:0] e_t  = eabs / `FTA_TEN;
  wire [7:0] e_u  = eabs % `FTA_TEN;
  wire [7:0] ch =
      sg == SG_EU  ? `FTA_CH_ZERO + e_u :
      sg == SG_ET  ? `FTA_CH_ZERO + e_t :
      sg == SG_ES  ? (dexp[7] ? `FTA_CH_MINUS : `FTA_CH_PLUS) :
      sg == SG_E   ? `FTA_CH_E :
      sg == SG_DOT ? `FTA_CH_DOT :
      sg == SG_PAD ? `FTA_CH_SPACE : `FTA_CH_ZERO + {4'h0, n_r};
  wire last_frac = cnt == f3 - 3'h1;
  fta_stage_t next_sg;
  assign next_sg =
      sg == SG_EU   ? SG_ET :
      sg == SG_ET   ? SG_ES :
      sg == SG_ES   ? SG_E :
      sg == SG_E    ? (f3 != '0 ? SG_FRAC : SG_INT) :
      sg == SG_FRAC ? (last_frac ? SG_DOT : SG_FRAC) :
      sg == SG_DOT  ? SG_INT :
      sg == SG_INT  ? (n_q == '0 ? SG_PAD : SG_INT) : SG_PAD;
  wire is_digit = sg == SG_FRAC || sg == SG_INT;
  // the sign slot is leftmost; digits still owed there do not fit
  wire overflow = pos == '0 && sg != SG_PAD;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign BUSY_O                  = st != ST_IDLE;
  assign FAULT_INDICATOR_O       = fault;
  assign ZERO_RESULT_INDICATOR_O = zero;

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_IDLE; sg <= SG_PAD; src <= '0; cf_fmt <= '0;
      cf_total <= '0; cf_frac <= '0; neg <= 1'b0; mant <= '0;
      bexp <= '0; dexp <= '0; n <= '0; pos <= '0; cnt <= '0;
      fault <= 1'b0; zero <= 1'b0; done <= 1'b0;
    end else begin
      case (st)
        ST_IDLE: if (go) begin
          src      <= {src_hi, src_lo};
          cf_fmt   <= fmt_r;
          cf_total <= total_r;
          cf_frac  <= frac_r;
          done     <= 1'b0;
          fault    <= 1'b0;
          zero     <= 1'b0;
          st       <= ST_CHECK;
        end
        ST_CHECK: if (err_any) begin
          fault <= 1'b1;
          done  <= 1'b1;
          st    <= ST_IDLE;
        end else begin
          neg  <= src[31];
          mant <= is_zero ? '0 : {fexp != '0, ffrac, 8'h00};
          bexp <= fexp == '0 ? `FTA_DENORM_EXP
                              : $signed({2'b00, fexp}) - `FTA_EXP_BIAS;
          dexp <= '0;
          st   <= (sci && !is_zero) ? ST_NORM : ST_ROUND;
        end
        ST_NORM: if (!mant[31] || ge10 || lt1) begin
          mant <= next_mant;
          bexp <= next_bexp;
          if (mant[31]) dexp <= ge10 ? dexp + 8'sh01 : dexp - 8'sh01;
        end else begin
          st <= ST_ROUND;
        end
        ST_ROUND: begin
          n    <= roll ? 160'(p10({1'b0, f3})) : n_round;
          if (roll) dexp <= dexp + 8'sh01;
          zero <= n_round == '0;
          pos  <= cf_total[4:0] - 5'h01;
          sg   <= sci ? SG_EU : (f3 != '0 ? SG_FRAC : SG_INT);
          cnt  <= '0;
          st   <= ST_EMIT;
        end
        ST_EMIT: if (overflow) begin
          fault <= 1'b1;
          zero  <= 1'b0;
          done  <= 1'b1;
          st    <= ST_IDLE;
        end else if (pos == '0) begin
          st <= ST_COMMIT;
        end else begin
          pos <= pos - 5'h01;
          sg  <= next_sg;
          if (is_digit) n <= n_q;
          if (sg == SG_FRAC) cnt <= cnt + 3'h1;
        end
        ST_COMMIT: begin
          done <= 1'b1;
          st   <= ST_IDLE;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // staging text, so that a late overflow leaves the destination alone
  always_ff @(posedge CORE_CLK_I) begin
    if (st == ST_EMIT && pos == '0)
      text[0] <= (neg && !zero) ? `FTA_CH_MINUS : `FTA_CH_SPACE;
    else if (st == ST_EMIT)
      text[pos] <= ch;
  end

  // ----------------------------------------------------------------
  // destination words
  // ----------------------------------------------------------------
  for (genvar w = 0; w < NW; w++) begin : g_dest
    wire hi_in = 2*w < int'(cf_total);
    wire lo_in = 2*w + 1 < int'(cf_total);
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n)
        dest[w] <= '0;
      else if (st == ST_COMMIT && w <= int'(cf_total[5:1]))
        dest[w] <= {hi_in ? text[2*w] : 8'h00,
                    lo_in ? text[2*w+1] : 8'h00};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_go;
    st == ST_IDLE && go;
  endsequence
  sequence s_fail;
    fault && done && st == ST_IDLE;
  endsequence

  a_go_taken: assert property (s_go |=> st == ST_CHECK)
    else $error("start not taken");
  a_go_ends: assert property (s_go |-> ##[3:250] done)
    else $error("conversion did not finish");
  a_fmt_fault: assert property ((st == ST_CHECK && fmt_bad) |=> s_fail)
    else $error("bad notation not flagged");
  a_nan_fault: assert property ((st == ST_CHECK && is_nan) |=> s_fail)
    else $error("nan not flagged");
  a_inf_fault: assert property ((st == ST_CHECK && is_inf) |=> s_fail)
    else $error("infinity not flagged");
  a_frac_fault: assert property ((st == ST_CHECK && frac_bad) |=> s_fail)
    else $error("fraction count not flagged");
  a_total_fault: assert property ((st == ST_CHECK && tot_bad) |=> s_fail)
    else $error("total count not flagged");
  a_err_nowrite: assert property ((st == ST_CHECK && err_any)
    |=> st == ST_IDLE && $stable(dest[0]))
    else $error("destination touched after fault");
  a_int_fit: assert property (overflow && st == ST_EMIT |=> s_fail)
    else $error("integer overflow not flagged");
  // a zero source has no leading digit to place, so it is left out
  a_sci_one: assert property ((st == ST_ROUND && sci && n_round != '0)
    |=> n < 160'(p10(f_up)) && n >= 160'(p10({1'b0, f3})))
    else $error("scientific mantissa not one digit");
  a_zero_set: assert property ((st == ST_ROUND && n_round == '0)
    |-> ##[2:30] (done && zero))
    else $error("zero result not flagged");
  a_zero_clr: assert property ((st == ST_ROUND && n_round != '0)
    |=> !zero [*2])
    else $error("zero flag on nonzero result");
  a_pack_hi: assert property (st == ST_COMMIT
    |=> dest[0] == {$past(text[0]), $past(text[1])})
    else $error("first word packed wrongly");
  a_term_word: assert property ((st == ST_COMMIT && !cf_total[0])
    |=> dest[cf_total[4:1]] == 16'h0000)
    else $error("terminator word missing");
endmodule // fta_formatter

// [dv/fta_seq_model.sv]
/*
  Sequencer model: AXI4-Lite master with one write and one read task.
  Assumes the bench calls the tasks one at a time, after reset.
*/
`timescale 1ns/1ps
module fta_seq_model (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // operands go in before the start write, flags are read after done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr_o  <= a;
    wdata_o   <= d;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
      if (bvalid_i) break;
    end
    bready_o <= 1'b0;
    wdata_o  <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'b0;
      if (rvalid_i) break;
    end
    rready_o <= 1'b0;
  endtask
endmodule // fta_seq_model

// [dv/float_to_ascii_formatter_bench.sv]
/*
  Self-checking bench of the float-to-text unit.
  Assumes the sequencer model drives the register bus.
*/
`timescale 1ns/1ps
module float_to_ascii_formatter_bench;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, flt, zr, busy;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int err_count = 0, checks_done = 0, seed = 41;
  logic [31:0] x;
  logic [79:0] ft[10] = '{
    {32'h7F800000, 48'h0000_0004_0001}, {32'hFF800000, 48'h0000_0004_0001},
    {32'h3F800000, 48'h0002_0004_0001}, {32'h3F800000, 48'h0000_0001_0000},
    {32'h3F800000, 48'h0000_0019_0000}, {32'h3F800000, 48'h0000_0004_0002},
    {32'h3F800000, 48'h0000_0018_0008}, {32'h3F800000, 48'h0001_0005_0000},
    {32'h3F800000, 48'h0001_0007_0001}, {32'h447A0000, 48'h0000_0004_0000}};
  initial forever #25 clk = ~clk;
  fta_formatter DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .FAULT_INDICATOR_O(flt),
    .ZERO_RESULT_INDICATOR_O(zr), .BUSY_O(busy));
  fta_seq_model SEQ (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awv),
    .awready_i(awr), .wdata_o(wdata), .wvalid_o(wv), .wready_i(wr_r),
    .bvalid_i(bv), .bready_o(br), .araddr_o(araddr), .arvalid_o(arv),
    .arready_i(arr), .rvalid_i(rv), .rready_o(rr));
  // ----------------------------------------------------------------
  // compares
  // ----------------------------------------------------------------
  task automatic cmp_r(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t read %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t write resp %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_f(input logic [1:0] g, input logic [1:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t flag ports %b expected %b", $time, g, e);
    end
  endtask
  always @(posedge clk) begin
    if (rv && rr) cmp_r({rdata, rresp}, rq.pop_front());
    if (bv && br) cmp_b(bresp, bq.pop_front());
  end
  task automatic w(input logic [7:0] a, input logic [15:0] d,
                   input logic [1:0] e);
    bq.push_back(e);
    SEQ.wr(a, {16'h0000, d});
  endtask
  task automatic r(input logic [7:0] a, input logic [15:0] e,
                   input logic [1:0] re);
    rq.push_back({16'h0000, e, re});
    SEQ.rd(a);
  endtask
  // stat holds {zero, fault, done, busy}
  task automatic conv(input logic [79:0] c, input logic [15:0] st);
    w(8'h00, c[63:48], 2'h0);
    w(8'h04, c[79:64], 2'h0);
    w(8'h08, c[47:32], 2'h0);
    w(8'h0C, c[31:16], 2'h0);
    w(8'h10, c[15:0], 2'h0);
    w(8'h14, 16'h0001, 2'h0);
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    r(8'h18, st, 2'h0);
    cmp_f({zr, flt}, st[3:2]);
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    conv({32'h3F800000, 48'h0000_0004_0001}, 16'h2);
    r(8'h40, 16'h2031, 2'h0);
    r(8'h44, 16'h2E30, 2'h0);
    r(8'h48, 16'h0000, 2'h0);
    conv({32'hC0100000, 48'h0000_0005_0001}, 16'h2);
    r(8'h40, 16'h2D20, 2'h0);
    r(8'h44, 16'h322E, 2'h0);
    r(8'h48, 16'h3300, 2'h0);
    conv({32'h3F800000, 48'h0001_0008_0001}, 16'h2);
    r(8'h48, 16'h452B, 2'h0);
    r(8'h4C, 16'h3030, 2'h0);
    r(8'h50, 16'h0000, 2'h0);
    conv({32'h80000000, 48'h0000_0002_0000}, 16'hA);
    r(8'h40, 16'h2030, 2'h0);
    conv({32'h3F800000, 48'h0000_0018_0000}, 16'h2);
    r(8'h6C, 16'h2031, 2'h0);
    r(8'h70, 16'h0000, 2'h0);
    foreach (ft[i]) begin
      conv(ft[i], 16'h6);
      r(8'h6C, 16'h2031, 2'h0);
    end
    repeat (3) begin
      x = $random(seed);
      conv({x[31], 8'hFF, x[22:1], 1'b1, 48'h0000_0004_0001}, 16'h6);
    end
    w(8'h18, 16'h0001, 2'h3);
    r(8'h30, 16'h0000, 2'h3);
    r(8'h02, 16'h0000, 2'h3);
    r(8'h14, 16'h0000, 2'h0);
    repeat (4) @(posedge clk);
    stop_test;
  end
endmodule // float_to_ascii_formatter_bench
